// file: design/divider_align.sv
// Integer input clock divider with phase-delayed realignment
`timescale 1ns/1ps
module divider_align
   import divsync_pkg::*;
#(
   parameter int DIV_RATIO = 1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic align_req,
   input wire logic [PHASE_W-1:0] phase,
   output logic busy,
   output logic align_done,
   output logic div_tick
);
   localparam logic [2:0] DIV_LAST = 3'(DIV_RATIO - 1);

   logic [2:0] div_cnt_ff;
   logic [PHASE_W-1:0] delay_ff;
   logic busy_ff;
   logic done_ff;
   logic tick_ff;
   logic align_now;

   // Code zero aligns at once, each step adds one cycle
   assign align_now = (align_req && !busy_ff && phase == '0) ||
                      (busy_ff && delay_ff == 3'h1); // RL8

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         busy_ff <= 1'b0;
         delay_ff <= '0;
      end else if (align_req && !busy_ff && phase != '0) begin
         busy_ff <= 1'b1;
         delay_ff <= phase; // RL8
      end else if (busy_ff) begin
         delay_ff <= delay_ff - 3'h1;
         busy_ff <= delay_ff != 3'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_cnt_ff <= '0;
      end else if (align_now || div_cnt_ff == DIV_LAST) begin
         div_cnt_ff <= '0;
      end else begin
         div_cnt_ff <= div_cnt_ff + 3'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         done_ff <= 1'b0;
         tick_ff <= 1'b0;
      end else begin
         done_ff <= align_now;
         tick_ff <= align_now || div_cnt_ff == DIV_LAST;
      end
   end

   assign busy = busy_ff;
   assign align_done = done_ff;
   assign div_tick = tick_ff;

   a_phase_load: assert property (@(posedge sys_clk) disable iff (rst)
      align_req && !busy_ff && phase != '0 |=>
      busy_ff && delay_ff == $past(phase)) // RL8
      else $error("phase delay not loaded");

   a_phase_align: assert property (@(posedge sys_clk) disable iff (rst)
      busy_ff && delay_ff == 3'h1 |=> div_cnt_ff == '0 && done_ff) // RL8
      else $error("divider not realigned after delay");
endmodule : divider_align

// file: design/divider_sync_control.sv
// Serial register port, sync gating and output control of the converter
// Notes on behaviour
// RL1: With master and divider sync enabled, next-only mode aligns to the first sync pulse and ignores later ones.
// RL2: In next-only mode the divider sync enable clears itself once alignment completes.
// RL3: Divider sync enable with master enable passes every sync pulse to realign the divider; here a pulse while div_busy is high is dropped.
// RL4: With master sync enable low every sync function is ignored; the host keeps it low when unused.
// RL5: After power-up the output type is CMOS until a register write changes it.
// RL6: The host selects LVDS outputs only by programming the output type register.
// RL7: Data outputs are disabled while the output disable pin is high.
// RL8: The phase field delays the divider alignment by zero to seven input clock cycles.
// RL9: The sync pin is synchronised and only its rising edge makes one alignment event.
`timescale 1ns/1ps
module divider_sync_control
   import divsync_pkg::*;
#(
   parameter int DIV_RATIO = 1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic sclk_pin,
   input wire logic csb_pin,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   input wire logic output_disable_pin,
   input wire logic sync_pin,
   input wire logic [7:0] self_test_sig_hi,
   output logic output_type_lvds,
   output logic outputs_enable,
   output logic dither_enable,
   output logic div_tick,
   output logic align_done
);
   pins_s pin_raw;
   pins_s sync1_ff;
   pins_s sync2_ff;
   pins_s sync3_ff;
   pins_s pin_ff;
   pins_s pin_prev_ff;
   logic sclk_rise;
   logic sclk_fall;
   logic sync_rise;

   logic [4:0] bit_cnt_ff;
   logic [FRAME_BITS-2:0] shift_ff;
   logic [FRAME_BITS-2:0] nxt_shift;
   logic rd_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [7:0] rd_shift_ff;
   logic sdio_out_ff;
   logic sdio_oe_ff;
   logic wr_strobe;
   logic [7:0] wr_data;

   logic [7:0] out_mode_ff;
   logic [7:0] clk_phase_ff;
   logic [7:0] dither_ff;
   sync_ctrl_s sync_ctrl_ff;
   logic outputs_enable_ff;

   logic align_req;
   logic div_busy;
   logic align_done_w;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ofs);
      hit = a == ofs;
   endfunction : hit

   // Three stages per pin; a change counts once stages two and three agree
   assign pin_raw = {sclk_pin, csb_pin, sdio_in, output_disable_pin,
                     sync_pin};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1_ff <= PINS_IDLE;
         sync2_ff <= PINS_IDLE;
         sync3_ff <= PINS_IDLE;
      end else begin
         sync1_ff <= pin_raw;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pin_ff <= PINS_IDLE;
         pin_prev_ff <= PINS_IDLE;
      end else begin
         pin_ff <= (sync2_ff & sync3_ff) | (pin_ff & (sync2_ff ^ sync3_ff));
         pin_prev_ff <= pin_ff;
      end
   end

   assign sclk_rise = pin_ff.sclk && !pin_prev_ff.sclk && !pin_ff.csb;
   assign sclk_fall = !pin_ff.sclk && pin_prev_ff.sclk && !pin_ff.csb;
   assign sync_rise = pin_ff.sync && !pin_prev_ff.sync; // RL9

   // Serial frame: 16-bit instruction, then one data byte, MSB first
   assign nxt_shift = {shift_ff[FRAME_BITS-3:0], pin_ff.sdio};
   assign wr_data = nxt_shift[7:0];
   assign wr_strobe = sclk_rise && bit_cnt_ff == FRAME_LAST && !rd_ff;

   always_ff @(posedge sys_clk) begin
      if (rst || pin_ff.csb) begin
         bit_cnt_ff <= '0;
         shift_ff <= '0;
      end else if (sclk_rise && bit_cnt_ff != FRAME_DONE) begin
         bit_cnt_ff <= bit_cnt_ff + 5'h01;
         shift_ff <= nxt_shift;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_ff <= 1'b0;
         addr_ff <= '0;
      end else if (sclk_rise && bit_cnt_ff == INSTR_LAST) begin
         rd_ff <= nxt_shift[INSTR_BITS-1];
         addr_ff <= nxt_shift[ADDR_W-1:0];
      end
   end

   // Read data shifts out on falling edges after the instruction
   always_ff @(posedge sys_clk) begin
      if (rst || pin_ff.csb) begin
         rd_shift_ff <= '0;
         sdio_out_ff <= 1'b0;
         sdio_oe_ff <= 1'b0;
      end else if (sclk_rise && bit_cnt_ff == INSTR_LAST) begin
         rd_shift_ff <= reg_read(nxt_shift[ADDR_W-1:0]);
      end else if (sclk_fall && rd_ff && bit_cnt_ff >= 5'(INSTR_BITS)) begin
         sdio_out_ff <= rd_shift_ff[7];
         rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
         sdio_oe_ff <= 1'b1;
      end
   end

   function automatic logic [7:0] reg_read(input logic [ADDR_W-1:0] a);
      reg_read = 8'h00;
      if (hit(a, OFS_OUT_MODE)) begin
         reg_read = out_mode_ff;
      end else if (hit(a, OFS_CLK_PHASE)) begin
         reg_read = clk_phase_ff;
      end else if (hit(a, OFS_SIG_HI)) begin
         reg_read = self_test_sig_hi;
      end else if (hit(a, OFS_DITHER)) begin
         reg_read = dither_ff;
      end else if (hit(a, OFS_SYNC_CTRL)) begin
         reg_read = {5'h00, sync_ctrl_ff};
      end
   endfunction : reg_read

   // Power-up selects CMOS; LVDS only through a register write
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         out_mode_ff <= RST_OUT_MODE; // RL5
         clk_phase_ff <= RST_CLK_PHASE;
         dither_ff <= RST_DITHER;
      end else if (wr_strobe) begin
         if (hit(addr_ff, OFS_OUT_MODE)) begin
            out_mode_ff <= wr_data & MASK_OUT_MODE; // RL6
         end
         if (hit(addr_ff, OFS_CLK_PHASE)) begin
            clk_phase_ff <= wr_data & MASK_CLK_PHASE;
         end
         if (hit(addr_ff, OFS_DITHER)) begin
            dither_ff <= wr_data & MASK_DITHER;
         end
      end
   end

   // Software write wins over the self-clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync_ctrl_ff <= RST_SYNC_CTRL;
      end else if (wr_strobe && hit(addr_ff, OFS_SYNC_CTRL)) begin
         sync_ctrl_ff <= wr_data[2:0];
      end else if (align_done_w && sync_ctrl_ff.next_only) begin
         sync_ctrl_ff.div_en <= 1'b0; // RL2
      end
   end

   // Busy and done windows block pulses before the self-clear lands
   assign align_req = sync_rise && sync_ctrl_ff.master_en && // RL4
                      sync_ctrl_ff.div_en && // RL3
                      !(sync_ctrl_ff.next_only &&
                        (div_busy || align_done_w)); // RL1

   divider_align #(
      .DIV_RATIO(DIV_RATIO)
   ) u_divider (
      .sys_clk(sys_clk),
      .rst(rst),
      .align_req(align_req),
      .phase(clk_phase_ff[PHASE_LSB +: PHASE_W]),
      .busy(div_busy),
      .align_done(align_done_w),
      .div_tick(div_tick)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         outputs_enable_ff <= 1'b0;
      end else begin
         outputs_enable_ff <= !pin_ff.out_dis &&
                              !out_mode_ff[OUT_DIS_BIT]; // RL7
      end
   end

   assign output_type_lvds = out_mode_ff[OUT_TYPE_BIT];
   assign dither_enable = dither_ff[DITHER_BIT];
   assign outputs_enable = outputs_enable_ff;
   assign align_done = align_done_w;
   assign sdio_out = sdio_out_ff;
   assign sdio_oe = sdio_oe_ff;

   a_cmos_default: assert property (@(posedge sys_clk)
      rst |=> !output_type_lvds) // RL5
      else $error("output type not CMOS after reset");

   a_lvds_by_write: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(output_type_lvds) |-> $past(wr_strobe) &&
      $past(hit(addr_ff, OFS_OUT_MODE))) // RL6
      else $error("output type changed without a write");

   a_master_gate: assert property (@(posedge sys_clk) disable iff (rst)
      !sync_ctrl_ff.master_en |-> !align_req) // RL4
      else $error("sync acted with master enable low");

   a_cont_mode: assert property (@(posedge sys_clk) disable iff (rst)
      sync_rise && sync_ctrl_ff.master_en && sync_ctrl_ff.div_en &&
      !sync_ctrl_ff.next_only && !div_busy |-> align_req ##1 align_done_w
      or align_req ##[1:8] align_done_w) // RL3
      else $error("sync pulse did not realign divider");

   a_sync_once: assert property (@(posedge sys_clk) disable iff (rst)
      align_req |=> !align_req [*2]) // RL9
      else $error("one sync edge made two events");

   a_next_clear: assert property (@(posedge sys_clk) disable iff (rst)
      align_done_w && sync_ctrl_ff.next_only &&
      !(wr_strobe && hit(addr_ff, OFS_SYNC_CTRL))
      |=> !sync_ctrl_ff.div_en) // RL2
      else $error("divider sync enable not self-cleared");

   a_next_ignore: assert property (@(posedge sys_clk) disable iff (rst)
      sync_ctrl_ff.next_only && align_req |=>
      !align_req throughout (div_busy or align_done_w)) // RL1
      else $error("later sync pulse accepted in next-only mode");

   a_out_disable: assert property (@(posedge sys_clk) disable iff (rst)
      pin_ff.out_dis |=> !outputs_enable) // RL7
      else $error("outputs enabled while disable pin high");
endmodule : divider_sync_control

// file: pkg/divsync_pkg.sv
// Shared constants and types for the divider sync control block
package divsync_pkg;
   localparam int ADDR_W = 13;
   localparam int INSTR_BITS = 16;
   localparam int FRAME_BITS = 24;
   localparam logic [4:0] INSTR_LAST = 5'h0F;
   localparam logic [4:0] FRAME_LAST = 5'h17;
   localparam logic [4:0] FRAME_DONE = 5'h18;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_OUT_MODE = 13'h0014;
   localparam logic [ADDR_W-1:0] OFS_CLK_PHASE = 13'h0016;
   localparam logic [ADDR_W-1:0] OFS_SIG_HI = 13'h0025;
   localparam logic [ADDR_W-1:0] OFS_DITHER = 13'h0030;
   localparam logic [ADDR_W-1:0] OFS_SYNC_CTRL = 13'h0100;

   // Values after reset
   localparam logic [7:0] RST_OUT_MODE = 8'h00;
   localparam logic [7:0] RST_CLK_PHASE = 8'h00;
   localparam logic [7:0] RST_DITHER = 8'h00;
   localparam logic [2:0] RST_SYNC_CTRL = 3'h0;

   // Writable bits of each register
   localparam logic [7:0] MASK_OUT_MODE = 8'hF7;
   localparam logic [7:0] MASK_CLK_PHASE = 8'h87;
   localparam logic [7:0] MASK_DITHER = 8'h10;

   // Field positions
   localparam int OUT_TYPE_BIT = 6;
   localparam int OUT_DIS_BIT = 4;
   localparam int DITHER_BIT = 4;
   localparam int PHASE_LSB = 0;
   localparam int PHASE_W = 3;

   localparam int SYNC_STAGES = 3;

   typedef struct packed {
      logic next_only;
      logic div_en;
      logic master_en;
   } sync_ctrl_s;

   typedef struct packed {
      logic sclk;
      logic csb;
      logic sdio;
      logic out_dis;
      logic sync;
   } pins_s;

   // Serial port idle, outputs held off until the pin is seen
   localparam pins_s PINS_IDLE = 5'h0A;
endpackage : divsync_pkg

// file: tb/divider_sync_control_tb_top.sv
// Self-checking bench of the divider sync control block
`timescale 1ns/1ps
module divider_sync_control_tb_top
   import divsync_pkg::*;
;
   typedef struct packed {
      logic [ADDR_W-1:0] ofs;
      logic [7:0] wr;
      logic [7:0] exp;
   } row_s;
   logic sys_clk, rst, sclk_pin, csb_pin, sdio_drv, sdio_wire, sdio_out;
   logic sdio_oe, output_disable_pin, sync_pin, output_type_lvds;
   logic outputs_enable, dither_enable, div_tick, align_done;
   logic [7:0] sig_hi, rd;
   int bad_count = 0;
   int checked = 0;
   int cnt, lat, lat7;
   row_s rows [6] = '{'{OFS_DITHER, 8'hFF, 8'h10},
      '{OFS_OUT_MODE, 8'hFF, 8'hF7}, '{OFS_CLK_PHASE, 8'hFF, 8'h87},
      '{OFS_SIG_HI, 8'hFF, 8'h5A}, '{OFS_SYNC_CTRL, 8'hF8, 8'h00},
      '{13'h0040, 8'hFF, 8'h00}};
   assign sdio_wire = sdio_oe ? sdio_out : sdio_drv;
   host_model host_model_i (.sys_clk(sys_clk), .sdio_wire(sdio_wire),
      .sclk_pin(sclk_pin), .csb_pin(csb_pin), .sdio_drv(sdio_drv),
      .output_disable_pin(output_disable_pin), .sync_pin(sync_pin));
   divider_sync_control #(.DIV_RATIO(4)) divider_sync_control_i (
      .sys_clk(sys_clk), .rst(rst), .sclk_pin(sclk_pin), .csb_pin(csb_pin),
      .sdio_in(sdio_wire), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .output_disable_pin(output_disable_pin), .sync_pin(sync_pin),
      .self_test_sig_hi(sig_hi), .output_type_lvds(output_type_lvds),
      .outputs_enable(outputs_enable), .dither_enable(dither_enable),
      .div_tick(div_tick), .align_done(align_done));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   task automatic wr(input logic [ADDR_W-1:0] ofs, input logic [7:0] d);
      host_model_i.xfer(1'b0, ofs, d, rd);
   endtask : wr
   task automatic rdr(input logic [ADDR_W-1:0] ofs);
      host_model_i.xfer(1'b1, ofs, 8'h00, rd);
   endtask : rdr
   // One sync pulse of w cycles; counts alignments in a fixed window
   task automatic pulse(input int w);
      cnt = 0;
      lat = 0;
      for (int c = 1; c <= 70; c++) begin
         @(negedge sys_clk);
         host_model_i.set_sync(c <= w);
         if (align_done === 1'b1) begin
            cnt++;
            if (lat == 0) lat = c;
            check(div_tick, 1'b1);
         end
      end
   endtask : pulse
   initial begin
      repeat (60000) @(posedge sys_clk);
      bad_count++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      sig_hi = 8'h5A;
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      repeat (10) @(negedge sys_clk);
      check(output_type_lvds, 1'b0);
      check(outputs_enable, 1'b0);
      rdr(OFS_SYNC_CTRL);
      check(rd, 8'h00);
      wr(OFS_OUT_MODE, 8'h40);
      check(output_type_lvds, 1'b1);
      check(outputs_enable, 1'b0);
      host_model_i.set_dis(1'b0);
      repeat (10) @(negedge sys_clk);
      check(outputs_enable, 1'b1);
      for (int i = 0; i < 6; i++) begin
         wr(rows[i].ofs, rows[i].wr);
         rdr(rows[i].ofs);
         check(rd, rows[i].exp);
      end
      check(dither_enable, 1'b1);
      check(outputs_enable, 1'b0);
      wr(OFS_SYNC_CTRL, 8'h03);
      pulse(8);
      check(8'(cnt), 8'h01);
      lat7 = lat;
      wr(OFS_CLK_PHASE, 8'h00);
      pulse(8);
      check(8'(lat7 - lat), 8'h07);
      pulse(40);
      check(8'(cnt), 8'h01);
      wr(OFS_SYNC_CTRL, 8'h02);
      pulse(8);
      check(8'(cnt), 8'h00);
      wr(OFS_SYNC_CTRL, 8'h01);
      pulse(8);
      check(8'(cnt), 8'h00);
      wr(OFS_SYNC_CTRL, 8'h07);
      pulse(8);
      check(8'(cnt), 8'h01);
      rdr(OFS_SYNC_CTRL);
      check(rd, 8'h05);
      pulse(8);
      check(8'(cnt), 8'h00);
      // Free-running divider, no alignment in this span
      cnt = 0;
      repeat (40) begin
         @(negedge sys_clk);
         if (div_tick === 1'b1) cnt++;
      end
      check(8'(cnt), 8'h0A);
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      repeat (10) @(negedge sys_clk);
      check(output_type_lvds, 1'b0);
      check(outputs_enable, 1'b1);
      check(dither_enable, 1'b0);
      rdr(OFS_DITHER);
      check(rd, 8'h00);
      summarize();
   end
endmodule : divider_sync_control_tb_top

// file: tb/host_model.sv
// Host side model: serial register port master and sync pulse source
`timescale 1ns/1ps
module host_model
   import divsync_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sdio_wire,
   output logic sclk_pin,
   output logic csb_pin,
   output logic sdio_drv,
   output logic output_disable_pin,
   output logic sync_pin
);
   initial begin
      sclk_pin = 1'b0;
      csb_pin = 1'b1;
      sdio_drv = 1'b0;
      output_disable_pin = 1'b1;
      sync_pin = 1'b0;
   end
   task automatic wait_n(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : wait_n
   // Output type only ever changes to LVDS through a frame like this one
   task automatic xfer(input logic rd, input logic [ADDR_W-1:0] ofs,
                       input logic [7:0] wdata, output logic [7:0] rdata);
      logic [23:0] frame;
      frame = {rd, 2'b00, ofs, wdata};
      rdata = 8'h00;
      @(negedge sys_clk);
      csb_pin = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         wait_n(1);
         sclk_pin = 1'b0;
         // Released line flips so a stale bit cannot pass as data
         sdio_drv = (rd && i < 8) ? ~sdio_drv : frame[i];
         wait_n(8);
         if (rd && i < 8) rdata[i] = sdio_wire;
         sclk_pin = 1'b1;
         wait_n(7);
      end
      wait_n(4);
      csb_pin = 1'b1;
      wait_n(1);
      sclk_pin = 1'b0;
      wait_n(6);
   endtask : xfer
   task automatic set_sync(input logic v);
      sync_pin = v;
   endtask : set_sync
   task automatic set_dis(input logic v);
      output_disable_pin = v;
   endtask : set_dis
endmodule : host_model
